// >>> src/sfp_core.sv
// Serial flash bus front end with protection, hold and page staging.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Works with hosts in clock modes 0 and 3 only.
// - Samples input on rising clock, shifts output from falling clock.
// - All transfers are whole eight-bit bytes.
// - One program takes one to 256 bytes, a single page.
// - Programming only clears bits; erase returns them to one.
// - Sector wipe sets one sector to ones, array wipe the whole array.
// - Busy flag stays set during status write, program or erase; readable.
// - Active while selected; after deselect, standby once operations end.
// - After deep sleep command, program and erase commands are ignored.
// - Write enable sets the latch; host sends it before modifying commands.
// - Latch clears at reset and after program, erase, disable, status write.
// - Three protect bits guard top 0,1,2,4,8,16,32 sectors or everything.
// - Lock bit set with protect pin low freezes lock and protect bits.
// - Write-class commands execute only if clock count is a multiple of 8.
// - Hold pauses the link but never aborts a running operation.
// - Hold starts at hold fall if clock low, else next clock fall.
// - Hold ends at hold rise if clock low, else next clock fall.
// - In hold the output floats and clock and data are ignored.
// - Select must stay low in hold; a rise there resets the interface.
module sfp_core
  import sfp_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic si,
  input wire logic hold_n,
  input wire logic wp_n,
  output logic so,
  output logic so_oe,
  output logic op_valid,
  input wire logic op_ready,
  output logic [1:0] op_kind,
  output logic [23:0] op_addr,
  output logic [7:0] op_data,
  input wire logic array_busy,
  output logic [7:0] status_and_protect,
  output logic standby,
  output logic deep_sleep,
  output logic hard_protection_mode
);

  logic [4:0] sync1;
  logic [4:0] sync2;
  logic sck_s, si_s, cs_s, hold_s, wp_s;
  logic sck_d, cs_d;
  logic rise_ok, fall_ok, cs_rise;
  logic in_hold;
  logic [2:0] bit_cnt;
  logic [2:0] byte_idx;
  logic [7:0] sh;
  logic [7:0] in_byte;
  logic byte_done;
  logic [7:0] cmd;
  logic [23:0] addr;
  logic [7:0] stat_new;
  logic [7:0] col;
  logic [7:0] page_mem [SFP_PAGE_BYTES];
  logic [SFP_PAGE_BYTES-1:0] page_used;
  logic [7:0] osh;
  logic write_enable_latch, status_lock_bit, asleep;
  logic [2:0] protect_sel;
  logic write_busy_flag;
  logic [6:0] prot_cnt;
  logic prot_hit, exec_go, accept, take;
  sfp_state_t state, next_state;
  logic [1:0] kind;
  logic [7:0] idx;
  logic [7:0] stat_cnt;
  logic buf_ready, buf_valid;
  logic [SFP_OP_W-1:0] buf_in, buf_out;

  // Every pin crosses two flops; only the second stage feeds logic.
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      sync1 <= SFP_PIN_IDLE;
      sync2 <= SFP_PIN_IDLE;
    end
    else
    begin
      sync1 <= {wp_n, hold_n, cs_n, si, sck};
      sync2 <= sync1;
    end
  end
  assign {wp_s, hold_s, cs_s, si_s, sck_s} = sync2;

  // Clock and select edges, found by the system clock.
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      sck_d <= 1'b0;
      cs_d <= 1'b1;
    end
    else
    begin
      sck_d <= sck_s;
      cs_d <= cs_s;
    end
  end
  // Either idle clock level works: only edges inside a select matter.
  assign rise_ok = sck_s & ~sck_d & ~cs_s & ~in_hold;
  assign fall_ok = ~sck_s & sck_d & ~cs_s & ~in_hold;
  assign cs_rise = cs_s & ~cs_d;

  // Hold follows the pin only while the clock is low, so a pin change
  // with the clock high takes effect at the next clock fall.
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n || cs_s)
      in_hold <= 1'b0;
    else if (!sck_s)
      in_hold <= ~hold_s;
  end

  // Bit and byte counting; deselect clears the counters and the shift register.
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n || cs_s)
    begin
      bit_cnt <= 3'h0;
      byte_idx <= 3'h0;
      sh <= 8'h00;
    end
    else if (rise_ok)
    begin
      sh <= in_byte;
      bit_cnt <= 3'(bit_cnt + 3'h1);
      if (bit_cnt == 3'h7 && byte_idx != SFP_LEN_PAGE_MIN)
        byte_idx <= 3'(byte_idx + 3'h1);
    end
  end
  assign in_byte = {sh[6:0], si_s};
  assign byte_done = rise_ok && (bit_cnt == 3'h7);

  // Command, address and payload capture.
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      cmd <= 8'h00;
      addr <= 24'h000000;
      stat_new <= 8'h00;
      col <= 8'h00;
    end
    else if (byte_done)
    begin
      unique case (byte_idx)
        3'h0: cmd <= in_byte;
        3'h1:
        begin
          addr[23:16] <= in_byte;
          stat_new <= in_byte;
        end
        3'h2: addr[15:8] <= in_byte;
        3'h3:
        begin
          addr[7:0] <= in_byte;
          col <= in_byte;
        end
        default: col <= 8'(col + 8'h01);
      endcase
    end
  end

  // Page staging: a byte written twice keeps only the zeros of both, and
  // the column wraps inside the page.
  assign accept = (state == SFP_IDLE) && !asleep;
  assign take = byte_done && accept && cmd == SFP_CMD_PAGE_WRITE
    && byte_idx >= SFP_LEN_SECTOR;
  always_ff @(posedge sys_clk)
  begin
    if (take)
      page_mem[col] <= page_used[col] ? (page_mem[col] & in_byte)
        : in_byte;
  end
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      page_used <= '0;
    else if (byte_done && byte_idx == 3'h0 && accept)
      page_used <= '0;
    else if (take)
      page_used[col] <= 1'b1;
  end

  // Status readout: reloaded each byte so polling sees live busy state.
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      so <= 1'b0;
      osh <= 8'h00;
    end
    else if (fall_ok && cmd == SFP_CMD_STATUS_READ && byte_idx != 3'h0)
    begin
      if (bit_cnt == 3'h0)
      begin
        so <= status_and_protect[7];
        osh <= {status_and_protect[6:0], 1'b0};
      end
      else
      begin
        so <= osh[7];
        osh <= {osh[6:0], 1'b0};
      end
    end
  end
  assign so_oe = ~cs_s & ~in_hold & ~asleep & (cmd == SFP_CMD_STATUS_READ)
    & (byte_idx != 3'h0);

  // Top-of-array protected sector count from the three select bits.
  assign prot_cnt = (protect_sel == 3'h7) ? SFP_SECTORS
    : (protect_sel == 3'h0) ? 7'h00
    : 7'(7'h01 << (protect_sel - 3'h1));
  assign prot_hit = (cmd == SFP_CMD_ARRAY_WIPE) ? (protect_sel != 3'h0)
    : ({1'b0, addr[21:16]} >= 7'(SFP_SECTORS - prot_cnt));
  assign hard_protection_mode = status_lock_bit & ~wp_s;

  // A command runs only if select rises outside hold on a byte boundary.
  assign exec_go = cs_rise && !in_hold && bit_cnt == 3'h0;

  // Latch, protection bits and deep sleep.
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      write_enable_latch <= SFP_ST_RESET[SFP_ST_WEL];
      protect_sel <= SFP_ST_RESET[SFP_ST_BP_HI:SFP_ST_BP_LO];
      status_lock_bit <= SFP_ST_RESET[SFP_ST_LOCK];
      asleep <= 1'b0;
    end
    else
    begin
      if (exec_go && accept && byte_idx == SFP_LEN_ONE)
      begin
        if (cmd == SFP_CMD_WRITE_ALLOW)
          write_enable_latch <= 1'b1;
        if (cmd == SFP_CMD_WRITE_FORBID)
          write_enable_latch <= 1'b0;
        if (cmd == SFP_CMD_SLEEP_DEEP)
          asleep <= 1'b1;
      end
      if (exec_go && asleep && cmd == SFP_CMD_WAKE)
        asleep <= 1'b0;
      if (state == SFP_IDLE && next_state == SFP_STATWR
          && !hard_protection_mode)
      begin
        protect_sel <= stat_new[SFP_ST_BP_HI:SFP_ST_BP_LO];
        status_lock_bit <= stat_new[SFP_ST_LOCK];
      end
      if (state != SFP_IDLE && next_state == SFP_IDLE)
        write_enable_latch <= 1'b0;
    end
  end

  // Operation sequencer: stages a page or an erase into the buffer, then
  // waits for the back end, so busy covers the whole array operation.
  always_comb
  begin
    next_state = state;
    unique case (state)
      SFP_IDLE:
        if (exec_go && accept && write_enable_latch)
        begin
          if (cmd == SFP_CMD_STATUS_WRITE && byte_idx == SFP_LEN_STATUS)
            next_state = SFP_STATWR;
          else if (((cmd == SFP_CMD_PAGE_WRITE
              && byte_idx == SFP_LEN_PAGE_MIN)
              || (cmd == SFP_CMD_SECTOR_WIPE && byte_idx == SFP_LEN_SECTOR)
              || (cmd == SFP_CMD_ARRAY_WIPE && byte_idx == SFP_LEN_ONE))
              && !prot_hit)
            next_state = SFP_PUSH;
        end
      SFP_PUSH:
        if (buf_ready && (kind != SFP_OP_PROG || idx == 8'hFF))
          next_state = SFP_DRAIN;
      SFP_STATWR:
        if (stat_cnt == 8'(SFP_STAT_WR_CYC - 1))
          next_state = SFP_IDLE;
      SFP_DRAIN:
        if (!buf_valid && !array_busy)
          next_state = SFP_IDLE;
    endcase
  end

  // Sequencer registers; hold and select never touch them.
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      state <= SFP_IDLE;
      kind <= SFP_OP_PROG;
      idx <= 8'h00;
      stat_cnt <= 8'h00;
    end
    else
    begin
      state <= next_state;
      if (state == SFP_IDLE)
      begin
        idx <= 8'h00;
        stat_cnt <= 8'h00;
        kind <= (cmd == SFP_CMD_SECTOR_WIPE) ? SFP_OP_SECT
          : (cmd == SFP_CMD_ARRAY_WIPE) ? SFP_OP_BULK : SFP_OP_PROG;
      end
      if (state == SFP_PUSH && buf_ready)
        idx <= 8'(idx + 8'h01);
      if (state == SFP_STATWR)
        stat_cnt <= 8'(stat_cnt + 8'h01);
    end
  end

  // Unwritten page bytes go out as erased, which leaves the array as is.
  assign buf_in = {kind,
    (kind == SFP_OP_PROG) ? {addr[23:8], idx} : addr,
    (kind != SFP_OP_PROG) ? SFP_ERASED
      : (page_used[idx] ? page_mem[idx] : SFP_ERASED)};

  sfp_pair_buf #(.WIDTH(SFP_OP_W)) sfp_pair_buf_inst (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .in_valid(state == SFP_PUSH),
    .in_ready(buf_ready),
    .in_data(buf_in),
    .out_valid(buf_valid),
    .out_ready(op_ready),
    .out_data(buf_out)
  );
  assign op_valid = buf_valid;
  assign {op_kind, op_addr, op_data} = buf_out;

  // Visible status and power state.
  assign write_busy_flag = (state != SFP_IDLE);
  assign status_and_protect = {status_lock_bit, 2'b00, protect_sel,
    write_enable_latch, write_busy_flag};
  assign standby = cs_s & ~write_busy_flag;
  assign deep_sleep = asleep;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_op_start;
    state == SFP_IDLE && next_state == SFP_PUSH;
  endsequence
  sequence s_stat_start;
    state == SFP_IDLE && next_state == SFP_STATWR;
  endsequence

  chk_hold_output_off: assert property (in_hold |-> !so_oe)
    else $error("output driven during hold");
  chk_hold_enter: assert property (!cs_s && !sck_s && !hold_s && !in_hold
    |=> in_hold)
    else $error("hold not entered with clock low");
  chk_hold_leave: assert property (!cs_s && !sck_s && hold_s && in_hold
    |=> !in_hold)
    else $error("hold not left with clock low");
  chk_hold_freezes_bits: assert property (in_hold && !cs_s && sck_s
    && !sck_d |=> $stable(bit_cnt))
    else $error("clock edge counted during hold");
  chk_sample_rising: assert property (
    rise_ok |=> sh[0] == $past(si_s))
    else $error("data not sampled on rising clock");
  chk_busy_op_span: assert property (
    s_op_start |=> write_busy_flag [*2])
    else $error("busy flag dropped during operation");
  chk_stat_wr_time: assert property (
    s_stat_start |=> write_busy_flag [*8])
    else $error("status write busy too short");
  chk_byte_boundary: assert property (state == SFP_IDLE
    && next_state != SFP_IDLE |-> bit_cnt == 3'h0 && cs_rise)
    else $error("command run off a byte boundary");
  chk_sleep_ignores: assert property (
    asleep |-> next_state != SFP_PUSH)
    else $error("array operation started in deep sleep");
  chk_protect_block: assert property (exec_go && prot_hit
    |-> next_state != SFP_PUSH)
    else $error("protected region was modified");
  chk_lock_frozen: assert property (hard_protection_mode
    |=> $stable({status_lock_bit, protect_sel}))
    else $error("locked status bits changed");
  chk_latch_clear: assert property (state != SFP_IDLE
    && next_state == SFP_IDLE |=> !write_enable_latch)
    else $error("write enable latch not cleared");
  chk_standby_wait: assert property (write_busy_flag |-> !standby)
    else $error("standby during operation");

endmodule
`default_nettype wire

// >>> src/sfp_pkg.sv
// Constants, field layout and state codes for the serial flash front end.
package sfp_pkg;

  // Status register field positions and reset value.
  localparam int SFP_ST_BUSY = 0;
  localparam int SFP_ST_WEL = 1;
  localparam int SFP_ST_BP_LO = 2;
  localparam int SFP_ST_BP_HI = 4;
  localparam int SFP_ST_LOCK = 7;
  localparam logic [7:0] SFP_ST_RESET = 8'h00;

  // Command codes on the serial link.
  localparam logic [7:0] SFP_CMD_WRITE_ALLOW = 8'h06;
  localparam logic [7:0] SFP_CMD_WRITE_FORBID = 8'h04;
  localparam logic [7:0] SFP_CMD_STATUS_READ = 8'h05;
  localparam logic [7:0] SFP_CMD_STATUS_WRITE = 8'h01;
  localparam logic [7:0] SFP_CMD_PAGE_WRITE = 8'h02;
  localparam logic [7:0] SFP_CMD_SECTOR_WIPE = 8'hD8;
  localparam logic [7:0] SFP_CMD_ARRAY_WIPE = 8'hC7;
  localparam logic [7:0] SFP_CMD_SLEEP_DEEP = 8'hB9;
  localparam logic [7:0] SFP_CMD_WAKE = 8'hAB;

  // Exact byte counts of the write-class commands; the page write count is a minimum.
  localparam logic [2:0] SFP_LEN_ONE = 3'h1;
  localparam logic [2:0] SFP_LEN_STATUS = 3'h2;
  localparam logic [2:0] SFP_LEN_SECTOR = 3'h4;
  localparam logic [2:0] SFP_LEN_PAGE_MIN = 3'h5;

  // Array operations handed to the storage back end.
  localparam logic [1:0] SFP_OP_PROG = 2'h0;
  localparam logic [1:0] SFP_OP_SECT = 2'h1;
  localparam logic [1:0] SFP_OP_BULK = 2'h2;
  localparam int SFP_OP_W = 34;

  // Array geometry.
  localparam int SFP_PAGE_BYTES = 256;
  localparam logic [6:0] SFP_SECTORS = 7'h40;
  localparam logic [7:0] SFP_ERASED = 8'hFF;

  // Sync flop reset value: {wp, hold, cs, si, sck} idle levels.
  localparam logic [4:0] SFP_PIN_IDLE = 5'h1C;

  // Status write busy time.
  localparam int SFP_CLK_MHZ = 20;
  localparam int SFP_STAT_WR_NS = 1000;
  localparam int SFP_STAT_WR_CYC = (SFP_STAT_WR_NS * SFP_CLK_MHZ) / 1000;

  // Operation sequencer, one-hot.
  typedef enum logic [3:0] {
    SFP_IDLE = 4'h1,
    SFP_PUSH = 4'h2,
    SFP_STATWR = 4'h4,
    SFP_DRAIN = 4'h8
  } sfp_state_t;

endpackage

// >>> src/sfp_pair_buf.sv
// Two-entry valid/ready buffer between the sequencer and the array back end.
`timescale 1ns/1ps
`default_nettype none
module sfp_pair_buf
  import sfp_pkg::*;
#(
  parameter int WIDTH = SFP_OP_W
)
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  logic [WIDTH-1:0] slot [2];
  logic wr_ptr;
  logic rd_ptr;
  logic [1:0] count;
  logic push;
  logic pop;

  // Full at two words, so a stalled back end holds the sequencer.
  assign in_ready = (count != 2'h2);
  assign out_valid = (count != 2'h0);
  assign out_data = slot[rd_ptr];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // Storage needs no reset; occupancy tells which words are live.
  always_ff @(posedge sys_clk)
  begin
    if (push)
      slot[wr_ptr] <= in_data;
  end

  // Pointers and occupancy.
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count <= 2'h0;
    end
    else
    begin
      if (push)
        wr_ptr <= ~wr_ptr;
      if (pop)
        rd_ptr <= ~rd_ptr;
      count <= 2'(count + {1'b0, push} - {1'b0, pop});
    end
  end

endmodule
`default_nettype wire

// >>> tb/sfp_host.sv
// Behavioural serial bus master that drives the flash front end pins.
`timescale 1ns/1ps
`default_nettype none
module sfp_host
(
  input wire logic sys_clk,
  output logic sck,
  output logic cs_n,
  output logic si,
  output logic hold_n,
  output logic wp_n,
  input wire logic so,
  input wire logic so_oe
);
  logic mode3;

  // Pins start at their idle levels; the clock parks low in mode 0.
  initial
  begin
    mode3 = 1'b0;
    sck = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
    hold_n = 1'b1;
    wp_n = 1'b1;
  end

  // All pin changes land on the falling system clock edge.
  task automatic tick(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  // Only modes 0 and 3 exist; the park level follows the mode.
  task automatic set_mode(input logic m);
    mode3 = m;
    sck = m;
    tick(4);
  endtask

  // Hold is released before select falls so the link does not pause.
  task automatic sel();
    hold_n = 1'b1;
    tick(4);
    cs_n = 1'b0;
    tick(4);
  endtask

  // One clock pulse of 400 ns; data is sampled just before the rise.
  // A released output is read as the inverse so a float never matches.
  task automatic pulse(input logic b, output logic r);
    sck = 1'b0;
    si = b;
    tick(4);
    r = so_oe ? so : ~so;
    sck = 1'b1;
    tick(4);
  endtask

  // Whole bytes, most significant bit first.
  task automatic xfer(input logic [7:0] b, output logic [7:0] r);
    for (int i = 7; i >= 0; i--)
      pulse(b[i], r[i]);
    if (!mode3)
      sck = 1'b0;
    tick(4);
  endtask

  // The clock parks before select rises, ending the frame.
  task automatic desel();
    sck = mode3;
    tick(4);
    cs_n = 1'b1;
    tick(4);
  endtask

  task automatic set_hold(input logic v);
    hold_n = v;
    tick(6);
  endtask

  // The protect pin is only moved between frames.
  task automatic set_wp(input logic v);
    wp_n = v;
    tick(5);
  endtask

  // Parks the clock low inside a frame, as after a pulse in hold.
  task automatic clk_low();
    sck = 1'b0;
    tick(4);
  endtask

  // Select rises without parking the clock first, e.g. while in hold.
  task automatic cs_up();
    cs_n = 1'b1;
    tick(6);
  endtask
endmodule
`default_nettype wire

// >>> tb/serial_flash_protect_hold_test.sv
// Self-checking bench for the serial flash front end.
`timescale 1ns/1ps
`default_nettype none
module serial_flash_protect_hold_test
  import sfp_pkg::*;
;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic op_ready = 1'b0;
  logic array_busy;
  logic be_on = 1'b0;
  logic be_stay = 1'b0;
  logic [2:0] be_cnt = 3'h0;
  logic sck, cs_n, si, hold_n, wp_n, so, so_oe, op_valid;
  logic [1:0] op_kind;
  logic [23:0] op_addr;
  logic [7:0] op_data, status_and_protect, rd, s;
  logic standby, deep_sleep, hard_protection_mode, b;
  logic [7:0] bytes[$];
  logic [33:0] ops[$];
  int n_errors = 0;
  int comparisons = 0;

  always #25 sys_clk = ~sys_clk;

  sfp_core sfp_core_inst (.sys_clk(sys_clk), .rst_n(rst_n), .sck(sck),
    .cs_n(cs_n), .si(si), .hold_n(hold_n), .wp_n(wp_n), .so(so),
    .so_oe(so_oe), .op_valid(op_valid), .op_ready(op_ready),
    .op_kind(op_kind), .op_addr(op_addr), .op_data(op_data),
    .array_busy(array_busy), .status_and_protect(status_and_protect),
    .standby(standby), .deep_sleep(deep_sleep),
    .hard_protection_mode(hard_protection_mode));

  sfp_host sfp_host_inst (.sys_clk(sys_clk), .sck(sck), .cs_n(cs_n),
    .si(si), .hold_n(hold_n), .wp_n(wp_n), .so(so), .so_oe(so_oe));

  // The back end side: every accepted array word is logged in order.
  always @(posedge sys_clk)
    if (op_valid === 1'b1 && op_ready === 1'b1)
      ops.push_back({op_kind, op_addr, op_data});

  // Back end model: takes a word every other cycle once enabled, so the
  // buffer both fills and drains, and stays busy a while after each word.
  always @(negedge sys_clk)
  begin
    op_ready <= be_on & ~op_ready;
    if (op_valid === 1'b1)
      be_cnt <= 3'h4;
    else if (be_cnt != 3'h0)
      be_cnt <= 3'(be_cnt - 3'h1);
  end
  assign array_busy = be_stay | (be_cnt != 3'h0);

  task automatic check(input string what, input logic [33:0] seen,
    input logic [33:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic finish_test();
    if (n_errors == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic tick(input int n);
    sfp_host_inst.tick(n);
  endtask

  // Sends the queued bytes as one selected frame.
  task automatic send();
    sfp_host_inst.sel();
    foreach (bytes[i])
      sfp_host_inst.xfer(bytes[i], rd);
    sfp_host_inst.desel();
  endtask

  task automatic cmd1(input logic [7:0] c);
    bytes = {c};
    send();
  endtask

  task automatic rd_status(output logic [7:0] v);
    sfp_host_inst.sel();
    sfp_host_inst.xfer(SFP_CMD_STATUS_READ, rd);
    sfp_host_inst.xfer(8'h00, v);
    sfp_host_inst.desel();
  endtask

  // Busy is looked at right after select rises, well inside 20 cycles.
  task automatic wr_status(input logic [7:0] v);
    cmd1(SFP_CMD_WRITE_ALLOW);
    bytes = {SFP_CMD_STATUS_WRITE, v};
    send();
    check("status busy", status_and_protect[SFP_ST_BUSY], 1'b1);
    tick(30);
  endtask

  task automatic t_reset();
    check("reset status", status_and_protect, SFP_ST_RESET);
    check("reset standby", standby, 1'b1);
    check("reset sleep", deep_sleep, 1'b0);
    check("reset so_oe", so_oe, 1'b0);
    check("reset op_valid", op_valid, 1'b0);
  endtask

  // Latch set and read back over the link in mode 3, then cleared.
  task automatic t_latch();
    sfp_host_inst.set_mode(1'b1);
    cmd1(SFP_CMD_WRITE_ALLOW);
    rd_status(s);
    check("latch read", s, 8'h02);
    cmd1(SFP_CMD_WRITE_FORBID);
    check("latch cleared", status_and_protect, 8'h00);
    wr_status(8'h04);
    check("status write", status_and_protect, 8'h04);
    sfp_host_inst.set_mode(1'b0);
  endtask

  // Nine clock pulses must not execute the write allow.
  task automatic t_count();
    sfp_host_inst.sel();
    sfp_host_inst.xfer(SFP_CMD_WRITE_ALLOW, rd);
    sfp_host_inst.pulse(1'b0, b);
    sfp_host_inst.desel();
    check("odd count", status_and_protect, 8'h04);
  endtask

  // Protected top sector refused, then a wrapping page under a stall.
  task automatic t_page();
    logic [7:0] e;
    cmd1(SFP_CMD_WRITE_ALLOW);
    bytes = {SFP_CMD_PAGE_WRITE, 8'h3F, 8'h00, 8'h00, 8'h11};
    send();
    tick(100);
    check("protected words", ops.size(), 0);
    check("latch kept", status_and_protect, 8'h06);
    bytes = {SFP_CMD_PAGE_WRITE, 8'h00, 8'h01, 8'hFE};
    bytes = {bytes, 8'hA5, 8'h3C, 8'h0F};
    send();
    tick(20);
    check("stall valid", op_valid, 1'b1);
    check("active busy", standby, 1'b0);
    be_stay = 1'b1;
    be_on = 1'b1;
    for (int i = 0; i < 800 && ops.size() < 256; i++)
      tick(1);
    check("page words", ops.size(), SFP_PAGE_BYTES);
    for (int i = 0; i < 256; i++)
    begin
      e = (i == 254) ? 8'hA5 : (i == 255) ? 8'h3C : (i == 0) ? 8'h0F : 8'hFF;
      check("page word", ops[i], {SFP_OP_PROG, 16'h0001, 8'(i), e});
    end
    rd_status(s);
    check("busy read", s, 8'h07);
    be_stay = 1'b0;
    tick(10);
    check("page done", status_and_protect, 8'h04);
    check("standby", standby, 1'b1);
  endtask

  task automatic t_erase();
    ops.delete();
    cmd1(SFP_CMD_WRITE_ALLOW);
    bytes = {SFP_CMD_SECTOR_WIPE, 8'h01, 8'h00, 8'h00};
    send();
    tick(20);
    check("sector word", ops[0], {SFP_OP_SECT, 24'h010000, 8'hFF});
    cmd1(SFP_CMD_WRITE_ALLOW);
    cmd1(SFP_CMD_ARRAY_WIPE);
    tick(20);
    check("bulk refused", ops.size(), 1);
    wr_status(8'h00);
    cmd1(SFP_CMD_WRITE_ALLOW);
    cmd1(SFP_CMD_ARRAY_WIPE);
    tick(20);
    check("bulk words", ops.size(), 2);
    check("bulk word", {ops[1][33:32], ops[1][7:0]},
      {SFP_OP_BULK, 8'hFF});
  endtask

  task automatic t_hard();
    wr_status(8'h88);
    sfp_host_inst.set_wp(1'b0);
    check("hard mode", hard_protection_mode, 1'b1);
    wr_status(8'h00);
    check("frozen bits", status_and_protect, 8'h88);
    sfp_host_inst.set_wp(1'b1);
    wr_status(8'h00);
    check("unfrozen", status_and_protect, 8'h00);
  endtask

  task automatic t_sleep();
    cmd1(SFP_CMD_SLEEP_DEEP);
    check("asleep", deep_sleep, 1'b1);
    cmd1(SFP_CMD_WRITE_ALLOW);
    check("asleep latch", status_and_protect, 8'h00);
    cmd1(SFP_CMD_WAKE);
    check("awake", deep_sleep, 1'b0);
  endtask

  // Clock pulses in hold are ignored; select rising in hold resets.
  task automatic t_hold();
    cmd1(SFP_CMD_WRITE_ALLOW);
    sfp_host_inst.sel();
    sfp_host_inst.xfer(SFP_CMD_STATUS_READ, rd);
    sfp_host_inst.set_hold(1'b0);
    check("hold float", so_oe, 1'b0);
    repeat (3) sfp_host_inst.pulse(1'b1, b);
    sfp_host_inst.clk_low();
    sfp_host_inst.set_hold(1'b1);
    sfp_host_inst.xfer(8'h00, s);
    sfp_host_inst.desel();
    check("hold read", s, 8'h02);
    sfp_host_inst.sel();
    sfp_host_inst.xfer(SFP_CMD_WRITE_FORBID, rd);
    sfp_host_inst.set_hold(1'b0);
    sfp_host_inst.cs_up();
    sfp_host_inst.set_hold(1'b1);
    check("hold reset", status_and_protect, 8'h02);
  endtask

  // The run needs about 5000 cycles; this span allows four times that.
  initial
  begin
    #1000000;
    n_errors++;
    finish_test();
  end

  initial
  begin
    repeat (12) @(negedge sys_clk);
    rst_n = 1'b1;
    tick(4);
    t_reset();
    t_latch();
    t_count();
    t_page();
    t_erase();
    t_hard();
    t_sleep();
    t_hold();
    finish_test();
  end
endmodule
`default_nettype wire
